// ---- rtl/pwg_pkg.sv ----
// Package: register map, field layout and reset values of the wake gating block
package pwg_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_EN_1X      = 8'h0B;
  localparam logic [7:0]  IDX_EN_2X      = 8'h0C;
  localparam logic [7:0]  IDX_EN_3X      = 8'h0D;
  localparam logic [7:0]  IDX_EN_5X      = 8'h0E;
  localparam logic [7:0]  IDX_RSVD       = 8'h0F;
  // Status registers, one per enable register, index + 0x10
  localparam logic [7:0]  IDX_STS_1X     = 8'h1B;
  localparam logic [7:0]  IDX_STS_2X     = 8'h1C;
  localparam logic [7:0]  IDX_STS_3X     = 8'h1D;
  localparam logic [7:0]  IDX_STS_5X     = 8'h1E;
  localparam logic [7:0]  IDX_CTRL       = 8'h20;
  localparam logic [7:0]  IDX_IRQ_STS    = 8'h21;
  localparam logic [7:0]  IDX_IRQ_CLR    = 8'h22;
  localparam logic [7:0]  IDX_IRQ_EN     = 8'h23;
  localparam logic [7:0]  IDX_OUT_STATE  = 8'h24;
  localparam int          NUM_BANKS      = 4;
  localparam int          NUM_SRC        = 32;
  localparam logic [7:0]  EN_RESET       = 8'h00;
  localparam logic [7:0]  STS_RESET      = 8'h00;
  localparam int          CTRL_GLOBAL_EN = 0;
  localparam logic        CTRL_RESET     = 1'b0;
  localparam int          IRQ_WAKE_EVENT = 0;
  localparam int          IRQ_OUT_ASSERT = 1;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;
  localparam int          GROUP_IRQ_BIT  = 11;
  localparam logic [31:0] RSVD_DATA      = 32'h0000_0000;
endpackage : pwg_pkg

// ---- rtl/pwg_src_if.sv ----
// Interface: per-source qualification between top and gating core
`timescale 1ns/100ps
interface pwg_src_if;
  logic [31:0] status;
  logic [31:0] enable;
  logic        global_en;
  logic [31:0] qualified;
  logic        any_qualified;
  modport top  (output status, output enable, output global_en,
                input qualified, input any_qualified);
  modport core (input status, input enable, input global_en,
                output qualified, output any_qualified);
endinterface : pwg_src_if

// ---- rtl/pwg_gate.sv ----
// Gating core: per-source wake qualification and OR reduction
`timescale 1ns/100ps
module pwg_gate (
  pwg_src_if.core src
);
  genvar g;
  generate
    for (g = 0; g < pwg_pkg::NUM_SRC; g++) begin : g_src
      assign src.qualified[g] = src.enable[g] & src.status[g] & src.global_en;
    end
  endgenerate
  assign src.any_qualified = |src.qualified;
endmodule : pwg_gate

// ---- rtl/pwg_top.sv ----
// Top: APB register file, wake status latching and active-low wake output
`timescale 1ns/100ps
module pwg_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  wake_evt_gpio_1x,
  input  wire logic [7:0]  wake_evt_gpio_2x_group,
  input  wire logic [7:0]  wake_evt_gpio_3x_4x_6x,
  input  wire logic [7:0]  wake_evt_gpio_5x,
  output logic             wake_request_out_n,
  output logic             irq
);

  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] evt_prev;
    logic [31:0] status;
    logic [31:0] wake_en;
    logic        global_event_enable;
    logic [1:0]  irq_sts;
    logic [1:0]  irq_en;
    logic        wake_out_n;
    logic [31:0] rdata;
  } pwg_state_t;

  pwg_state_t  st_reg;
  pwg_state_t  st_next;

  pwg_src_if src ();

  pwg_gate u_gate (
    .src (src)
  );

  assign src.status    = st_reg.status;
  assign src.enable    = st_reg.wake_en;
  assign src.global_en = st_reg.global_event_enable;

  logic [31:0] evt_raw;
  logic [31:0] evt_rise;
  logic        wr_acc;
  logic        rd_acc;
  logic [9:0]  widx;
  logic        addr_ok;
  logic [7:0]  idx;

  // Bank layout: bit 8*b+n is bit n of enable register 0B+b
  // lines 10..17 in bank 0
  // bank 1, bit 3 grouped device irq
  assign evt_raw  = {wake_evt_gpio_5x, wake_evt_gpio_3x_4x_6x,
                     wake_evt_gpio_2x_group, wake_evt_gpio_1x};
  assign evt_rise = st_reg.sync2 & ~st_reg.evt_prev;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & ~penable & ~pwrite;
  assign widx     = paddr[11:2];
  assign addr_ok  = (paddr[1:0] == 2'h0) && (widx[9:8] == 2'h0);
  assign idx      = widx[7:0];

  // Read mux, registered in the setup cycle so data is valid in the access phase
  function automatic logic [31:0] rd_mux(input pwg_state_t s, input logic [31:0] en,
                                         input logic [7:0] i, input logic ok);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (!ok) begin
      r = 32'h0000_0000;
    end else if (i == pwg_pkg::IDX_EN_1X) begin
      r = {24'h00_0000, en[7:0]};
    end else if (i == pwg_pkg::IDX_EN_2X) begin
      r = {24'h00_0000, en[15:8]};
    end else if (i == pwg_pkg::IDX_EN_3X) begin
      r = {24'h00_0000, en[23:16]};
    end else if (i == pwg_pkg::IDX_EN_5X) begin
      r = {24'h00_0000, en[31:24]};
    end else if (i == pwg_pkg::IDX_RSVD) begin
      r = pwg_pkg::RSVD_DATA;
    end else if (i == pwg_pkg::IDX_STS_1X) begin
      r = {24'h00_0000, s.status[7:0]};
    end else if (i == pwg_pkg::IDX_STS_2X) begin
      r = {24'h00_0000, s.status[15:8]};
    end else if (i == pwg_pkg::IDX_STS_3X) begin
      r = {24'h00_0000, s.status[23:16]};
    end else if (i == pwg_pkg::IDX_STS_5X) begin
      r = {24'h00_0000, s.status[31:24]};
    end else if (i == pwg_pkg::IDX_CTRL) begin
      r = {31'h0000_0000, s.global_event_enable};
    end else if (i == pwg_pkg::IDX_IRQ_STS) begin
      r = {30'h0000_0000, s.irq_sts};
    end else if (i == pwg_pkg::IDX_IRQ_EN) begin
      r = {30'h0000_0000, s.irq_en};
    end else if (i == pwg_pkg::IDX_OUT_STATE) begin
      r = {31'h0000_0000, ~s.wake_out_n};
    end
    return r;
  endfunction : rd_mux

  function automatic logic is_known(input logic [7:0] i);
    return (i == pwg_pkg::IDX_EN_1X) || (i == pwg_pkg::IDX_EN_2X)
        || (i == pwg_pkg::IDX_EN_3X) || (i == pwg_pkg::IDX_EN_5X)
        || (i == pwg_pkg::IDX_RSVD) || (i == pwg_pkg::IDX_STS_1X)
        || (i == pwg_pkg::IDX_STS_2X) || (i == pwg_pkg::IDX_STS_3X)
        || (i == pwg_pkg::IDX_STS_5X) || (i == pwg_pkg::IDX_CTRL)
        || (i == pwg_pkg::IDX_IRQ_STS) || (i == pwg_pkg::IDX_IRQ_CLR)
        || (i == pwg_pkg::IDX_IRQ_EN) || (i == pwg_pkg::IDX_OUT_STATE);
  endfunction : is_known

  always_comb begin
    logic [31:0] clr;
    logic [1:0]  irq_set;
    logic [1:0]  irq_clr;
    clr          = 32'h0000_0000;
    irq_set      = 2'h0;
    irq_clr      = 2'h0;
    st_next      = st_reg;
    // Two-flop synchroniser; only sync2 is looked at
    st_next.sync1    = evt_raw;
    st_next.sync2    = st_reg.sync1;
    st_next.evt_prev = st_reg.sync2;
    if (wr_acc && addr_ok && pstrb[0]) begin
      if (idx == pwg_pkg::IDX_EN_1X) begin
        st_next.wake_en[7:0] = pwdata[7:0];
      end else if (idx == pwg_pkg::IDX_EN_2X) begin
        st_next.wake_en[15:8] = pwdata[7:0];
      end else if (idx == pwg_pkg::IDX_EN_3X) begin
        st_next.wake_en[23:16] = pwdata[7:0];
      end else if (idx == pwg_pkg::IDX_EN_5X) begin
        st_next.wake_en[31:24] = pwdata[7:0];
      end else if (idx == pwg_pkg::IDX_STS_1X) begin
        clr[7:0] = pwdata[7:0];
      end else if (idx == pwg_pkg::IDX_STS_2X) begin
        clr[15:8] = pwdata[7:0];
      end else if (idx == pwg_pkg::IDX_STS_3X) begin
        clr[23:16] = pwdata[7:0];
      end else if (idx == pwg_pkg::IDX_STS_5X) begin
        clr[31:24] = pwdata[7:0];
      end else if (idx == pwg_pkg::IDX_CTRL) begin
        st_next.global_event_enable = pwdata[pwg_pkg::CTRL_GLOBAL_EN];
      end else if (idx == pwg_pkg::IDX_IRQ_CLR) begin
        irq_clr = pwdata[1:0];
      end else if (idx == pwg_pkg::IDX_IRQ_EN) begin
        st_next.irq_en = pwdata[1:0];
      end
    end
    st_next.status = (st_reg.status & ~clr) | evt_rise;
    // output tracks OR of qualified sources
    st_next.wake_out_n = ~src.any_qualified;
    irq_set[pwg_pkg::IRQ_WAKE_EVENT] = |evt_rise;
    irq_set[pwg_pkg::IRQ_OUT_ASSERT] = st_reg.wake_out_n & src.any_qualified;
    st_next.irq_sts = (st_reg.irq_sts & ~irq_clr) | irq_set;
    if (rd_acc) begin
      st_next.rdata = rd_mux(st_reg, st_reg.wake_en, idx, addr_ok);
    end
  end

  // presetn is the standby-supply power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.wake_en             <= {pwg_pkg::NUM_BANKS{pwg_pkg::EN_RESET}};
      st_reg.sync1               <= 32'h0000_0000;
      st_reg.sync2               <= 32'h0000_0000;
      st_reg.evt_prev            <= 32'h0000_0000;
      st_reg.status              <= {pwg_pkg::NUM_BANKS{pwg_pkg::STS_RESET}};
      st_reg.global_event_enable <= pwg_pkg::CTRL_RESET;
      st_reg.irq_sts             <= pwg_pkg::IRQ_RESET;
      st_reg.irq_en              <= pwg_pkg::IRQ_RESET;
      st_reg.wake_out_n          <= 1'b1;
      st_reg.rdata               <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero-wait slave; unmapped or misaligned access answers with pslverr
  assign pready             = 1'b1;
  assign pslverr            = psel & penable & (~addr_ok | ~is_known(idx)
                              | (pwrite & (idx == pwg_pkg::IDX_RSVD)));
  assign prdata             = st_reg.rdata;
  assign wake_request_out_n = st_reg.wake_out_n;
  assign irq                = |(st_reg.irq_sts & st_reg.irq_en);

endmodule : pwg_top

// ---- tb/pwg_monitor.sv ----
// Checker: bus and wake output relations at the top ports
`timescale 1ns/100ps
module pwg_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  wake_evt_gpio_1x,
  input wire logic [7:0]  wake_evt_gpio_2x_group,
  input wire logic [7:0]  wake_evt_gpio_3x_4x_6x,
  input wire logic [7:0]  wake_evt_gpio_5x,
  input wire logic        wake_request_out_n,
  input wire logic        irq
);
  logic [31:0] evv;
  logic [31:0] evv_reg;
  logic [7:0]  rh_reg;
  logic [7:0]  wh_reg;
  logic        wr;
  logic        rd;
  assign evv = {wake_evt_gpio_5x, wake_evt_gpio_3x_4x_6x, wake_evt_gpio_2x_group,
                wake_evt_gpio_1x};
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // History windows: the synchroniser delays an event by several edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evv_reg <= 32'h0;
      rh_reg  <= 8'h00;
      wh_reg  <= 8'h00;
    end else begin
      evv_reg <= evv;
      rh_reg  <= {rh_reg[6:0], |(evv & ~evv_reg)};
      wh_reg  <= {wh_reg[6:0], wr};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_high; pready; endproperty
  property p_setup_no_err; psel && !penable |-> !pslverr; endproperty
  property p_rsvd_read; rd && paddr == 12'h03C |-> prdata == 32'h0 && !pslverr; endproperty
  property p_rsvd_write; wr && paddr == 12'h03C |-> pslverr; endproperty
  property p_en_upper;
    rd && paddr inside {12'h02C, 12'h030, 12'h034, 12'h038} |-> prdata[31:8] == 24'h0;
  endproperty
  property p_wake_fall; $fell(wake_request_out_n) |-> (rh_reg | wh_reg) != 8'h00; endproperty
  property p_wake_rise; $rose(wake_request_out_n) |-> wh_reg != 8'h00; endproperty
  property p_irq_cause; $rose(irq) |-> (rh_reg | wh_reg) != 8'h00; endproperty
  a_ready_high: assert property (p_ready_high)
    else $error("pready low");
  a_setup_no_err: assert property (p_setup_no_err)
    else $error("error in setup cycle");
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved slot read not zero");
  a_rsvd_write: assert property (p_rsvd_write)
    else $error("reserved slot write accepted");
  a_en_upper: assert property (p_en_upper)
    else $error("enable upper bits not zero");
  a_wake_fall: assert property (p_wake_fall)
    else $error("wake asserted without cause");
  a_wake_rise: assert property (p_wake_rise)
    else $error("wake released without write");
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq raised without cause");
  c_wake: cover property ($fell(wake_request_out_n));
  c_irq: cover property ($rose(irq));
  c_rsvd: cover property (wr && paddr == 12'h03C);
endmodule : pwg_monitor

bind pwg_top pwg_monitor pwg_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .wake_evt_gpio_1x, .wake_evt_gpio_2x_group,
  .wake_evt_gpio_3x_4x_6x, .wake_evt_gpio_5x, .wake_request_out_n, .irq);

// ---- tb/pwg_chipset_model.sv ----
// Partner: chipset side counting wake requests
`timescale 1ns/100ps
module pwg_chipset_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic wake_request_out_n,
  output int        wake_count
);
  logic seen_reg;
  // A level held low is one request, not one per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg   <= 1'b0;
      wake_count <= 0;
    end else begin
      seen_reg <= !wake_request_out_n;
      if (!wake_request_out_n && !seen_reg) begin
        wake_count <= wake_count + 1;
      end
    end
  end
endmodule : pwg_chipset_model

// ---- tb/tb_top.sv ----
// Testbench: registers, wake gating, interrupt and reset scenarios
`timescale 1ns/100ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_n, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic [7:0]  ev [4];
  int          num_errors, checked, wake_count;

  pwg_top pwg_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .wake_evt_gpio_1x(ev[0]), .wake_evt_gpio_2x_group(ev[1]),
    .wake_evt_gpio_3x_4x_6x(ev[2]), .wake_evt_gpio_5x(ev[3]),
    .wake_request_out_n(wake_n), .irq);
  pwg_chipset_model pwg_chipset_model_i (.pclk, .presetn, .wake_request_out_n(wake_n),
    .wake_count);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rdat);
  endtask : rd

  task settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle

  // Held three edges so the two-flop synchroniser sees one clean rise
  task pulse(input int b, input int i);
    @(posedge pclk);
    ev[b][i] <= 1'b1;
    repeat (3) @(posedge pclk);
    ev[b][i] <= 1'b0;
    settle;
  endtask : pulse

  task t_regs;
    for (int b = 0; b < 5; b++) begin
      rd(12'h02C + 12'(4 * b), 32'h0, "reset value");
      wr(12'h02C + 12'(4 * b), 32'hA5 ^ 32'(b));
      rd(12'h02C + 12'(4 * b), (b == 4) ? 32'h0 : 32'hA5 ^ 32'(b), "enable");
      wr(12'h02C + 12'(4 * b), 32'h0);
    end
    pstrb <= 4'h0;
    wr(12'h02C, 32'hFF);
    pstrb <= 4'hF;
    rd(12'h02C, 32'h0, "strobe off write");
    apb(12'h03C, 1'b1, 32'hFF);
    chk("reserved write error", 32'h1, 32'(err));
    apb(12'h3F0, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
  endtask : t_regs

  task t_gate;
    int i;
    wr(12'h080, 32'h1);
    for (int b = 0; b < 4; b++) begin
      i = (b == 1) ? 3 : 2 * b + 1;
      wr(12'h02C + 12'(4 * b), 32'h1 << i);
      pulse(b, i ^ 1);
      chk("neighbour gated", 32'h1, 32'(wake_n));
      pulse(b, i);
      chk("wake asserted", 32'h0, 32'(wake_n));
      rd(12'h06C + 12'(4 * b), 32'h3 << (i & 6), "status");
      wr(12'h06C + 12'(4 * b), 32'h3 << (i & 6));
      settle;
      chk("wake released", 32'h1, 32'(wake_n));
      wr(12'h02C + 12'(4 * b), 32'h0);
    end
  endtask : t_gate

  task t_global;
    wr(12'h080, 32'h0);
    wr(12'h030, 32'h8);
    pulse(1, 3);
    chk("global off", 32'h1, 32'(wake_n));
    wr(12'h080, 32'h1);
    settle;
    chk("global on", 32'h0, 32'(wake_n));
    rd(12'h080, 32'h1, "global enable");
    rd(12'h090, 32'h1, "output state");
    wr(12'h070, 32'h0);
    settle;
    chk("zero write kept", 32'h0, 32'(wake_n));
    wr(12'h080, 32'h0);
    settle;
    chk("global dropped", 32'h1, 32'(wake_n));
    rd(12'h090, 32'h0, "output state off");
    wr(12'h070, 32'h8);
    wr(12'h030, 32'h0);
  endtask : t_global

  task t_irq;
    wr(12'h088, 32'h3);
    wr(12'h08C, 32'h1);
    rd(12'h08C, 32'h1, "irq enable");
    rd(12'h088, 32'h0, "irq clear reads zero");
    pulse(3, 7);
    chk("irq raised", 32'h1, 32'(irq));
    wr(12'h088, 32'h1);
    settle;
    chk("irq cleared", 32'h0, 32'(irq));
    wr(12'h08C, 32'h0);
    pulse(3, 6);
    chk("irq masked", 32'h0, 32'(irq));
    rd(12'h084, 32'h1, "irq status");
    chk("wake requests", 32'h5, 32'(wake_count));
    wr(12'h02C, 32'hFF);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h02C, 32'h0, "enable after power-on");
  endtask : t_irq

  task wrap_up;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, num_errors, checked} = '0;
    pstrb = 4'hF;
    ev = '{default: 8'h00};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_gate;
    t_global;
    t_irq;
    wrap_up;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up;
  end
endmodule : tb_top
